// ---- tgp_prov.v ----
// Purpose: per-group rate, stream-activity and clock-source provisioning for a
//          32+32 group tdm switch, programmed over apb
// Assumes: sys_clk 100 MHz; aux link clocks are sampled as plain inputs
// Notes:   register outputs are flat buses, 32 groups x 4 lanes, 2 bits or 1 bit
`timescale 1ns/1ps
`include "tgp_map.vh"

// Functional notes
// - 32 input and 32 output groups, lanes a-d share one word
// - 65M only lane a, 32M lanes a,b, lower rates all four
// - group capacity 1024 channels, 512 at 8.192 Mbps
// - input rate bits 3:2, output rate bits 19:18 of group word
// - input and output rates programmed independently
// - group word source selects at bits 1:0 and 17:16
// - output clock word sources at 22:21, 15:14, 8:7, 1:0
// - two straps fix master clock frequency, 00 8M to 11 65M
// - reset gives st-bus negative; bits 2,1,0 format, fp, clk pol
// - master clock drives internal logic and must always run
// - aux clock frequencies are detected automatically, independently
// - lane carries 1024/512/256/128 channels at 65/32/16/8 Mbps
module tgp_prov (
  input  wire                   sys_clk,
  input  wire                   rst_b,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`TGP_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire [1:0]             master_freq_strap,
  input  wire [1:0]             aux_clock_in,
  input  wire [1:0]             aux_frame_pulse_in,
  output reg  [127:0]           in_lane_active,
  output reg  [127:0]           out_lane_active,
  output reg  [63:0]            in_group_clk_source_sel,
  output reg  [63:0]            out_group_clk_source_sel,
  output reg  [63:0]            in_group_rate,
  output reg  [63:0]            out_group_rate,
  output reg  [31:0]            in_group_half_cap,
  output reg  [31:0]            out_group_half_cap,
  output reg  [1:0]             out_clock3_source_sel,
  output reg  [1:0]             out_clock2_source_sel,
  output reg  [1:0]             out_clock1_source_sel,
  output reg  [1:0]             out_clock0_source_sel,
  output reg                    master_frame_format_sel,
  output reg                    master_frame_pulse_polarity,
  output reg                    master_clock_polarity,
  output reg  [1:0]             master_freq,
  output reg  [3:0]             aux_freq
);

  // ==========================================================
  // register storage
  reg  [31:0]  group_control_word [0:31];
  reg  [31:0]  output_clock_control_word;
  reg  [2:0]   input_clock_control_word;
  reg  [1:0]   strap_meta;
  reg  [1:0]   strap_sync;
  reg  [1:0]   aux_ck_meta;
  reg  [1:0]   aux_ck_sync;
  reg  [1:0]   aux_ck_prev;
  reg  [1:0]   aux_fp_meta;
  reg  [1:0]   aux_fp_sync;
  reg  [`TGP_CNT_W-1:0]  frame_cnt;
  reg  [`TGP_EDGE_W-1:0] edge_cnt [0:1];
  reg  [1:0]   aux_rate [0:1];
  wire         wr_en;
  wire         rd_en;
  wire         grp_hit;
  wire [4:0]   grp_idx;
  wire         frame_end;
  reg  [31:0]  next_prdata;
  reg          next_err;

  // apb with one wait state: setup then access, pready raised the cycle after access starts
  assign wr_en     = psel & penable & pwrite & ~pready;
  assign rd_en     = psel & penable & ~pwrite & ~pready;
  assign grp_hit   = (paddr < `TGP_GRP_LIMIT) && (paddr[1:0] == 2'h0);
  assign grp_idx   = paddr[6:2];
  assign frame_end = (frame_cnt == (`TGP_FRAME_CYC - 1));

  // ==========================================================
  // read mux and unmapped decode
  always @* begin
    next_prdata = 32'h00000000;
    next_err    = 1'b0;
    if (grp_hit) begin
      next_prdata = group_control_word[grp_idx];
    end else begin
      case (paddr)
        `TGP_OFS_IN_CLK:   next_prdata = {29'h0, input_clock_control_word};
        `TGP_OFS_OUT_CLK:  next_prdata = output_clock_control_word;
        `TGP_OFS_STATUS:   next_prdata = {30'h0, strap_sync};
        `TGP_OFS_AUX_RATE: next_prdata = {28'h0, aux_rate[1], aux_rate[0]};
        default:           next_err    = 1'b1;
      endcase
    end
  end

  // apb answer; read-only words reject writes with pslverr
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= rd_en ? next_prdata : 32'h00000000;
      pslverr <= (rd_en | wr_en) & (next_err |
                 (pwrite & ((paddr == `TGP_OFS_STATUS) | (paddr == `TGP_OFS_AUX_RATE))));
    end
  end

  // ==========================================================
  // per-group control words and derived lane enables
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : grp
      // one word per group shared by all four lanes
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          group_control_word[g] <= `TGP_GROUP_RESET;
        end else if (wr_en && grp_hit && grp_idx == g) begin
          group_control_word[g] <= pwdata & `TGP_GROUP_MASK;
        end
      end
      // lane activity: a always, b from 32M down, c/d at 16M and 8M
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          in_lane_active[4*g+3:4*g]      <= 4'hF;
          out_lane_active[4*g+3:4*g]     <= 4'hF;
          in_group_rate[2*g+1:2*g]       <= `TGP_RATE_8M;
          out_group_rate[2*g+1:2*g]      <= `TGP_RATE_8M;
          in_group_half_cap[g]           <= 1'b1;
          out_group_half_cap[g]          <= 1'b1;
          in_group_clk_source_sel[2*g+1:2*g]  <= `TGP_SRC_SYS;
          out_group_clk_source_sel[2*g+1:2*g] <= `TGP_SRC_SYS;
        end else begin
          // input and output sides decode separate fields
          in_lane_active[4*g+3:4*g]  <= lanes(group_control_word[g][`TGP_IN_RATE_HI:`TGP_IN_RATE_LO]);
          out_lane_active[4*g+3:4*g] <= lanes(group_control_word[g][`TGP_OUT_RATE_HI:`TGP_OUT_RATE_LO]);
          in_group_rate[2*g+1:2*g]   <= group_control_word[g][`TGP_IN_RATE_HI:`TGP_IN_RATE_LO];
          out_group_rate[2*g+1:2*g]  <= group_control_word[g][`TGP_OUT_RATE_HI:`TGP_OUT_RATE_LO];
          // 8M: four lanes of 128 gives 512, else 1024
          in_group_half_cap[g]  <= group_control_word[g][`TGP_IN_RATE_HI:`TGP_IN_RATE_LO]
                                   == `TGP_RATE_8M;
          out_group_half_cap[g] <= group_control_word[g][`TGP_OUT_RATE_HI:`TGP_OUT_RATE_LO]
                                   == `TGP_RATE_8M;
          in_group_clk_source_sel[2*g+1:2*g]  <=
            group_control_word[g][`TGP_IN_SRC_HI:`TGP_IN_SRC_LO];
          out_group_clk_source_sel[2*g+1:2*g] <=
            group_control_word[g][`TGP_OUT_SRC_HI:`TGP_OUT_SRC_LO];
        end
      end
    end
  endgenerate

  // lane enable pattern for a rate code, lane a in bit 0
  function [3:0] lanes;
    input [1:0] rate;
    begin
      case (rate)
        `TGP_RATE_65M: lanes = 4'h1;
        `TGP_RATE_32M: lanes = 4'h3;
        default:       lanes = 4'hF;
      endcase
    end
  endfunction

  // ==========================================================
  // output and input clock control words
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_clock_control_word <= `TGP_OCK_RESET;
      input_clock_control_word  <= `TGP_ICK_RESET;
    end else if (wr_en) begin
      if (paddr == `TGP_OFS_OUT_CLK) begin
        output_clock_control_word <= pwdata & `TGP_OCK_MASK;
      end
      if (paddr == `TGP_OFS_IN_CLK) begin
        input_clock_control_word <= pwdata[2:0];
      end
    end
  end

  // registered copies of the selector and polarity fields
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_clock3_source_sel       <= `TGP_SRC_SYS;
      out_clock2_source_sel       <= `TGP_SRC_SYS;
      out_clock1_source_sel       <= `TGP_SRC_SYS;
      out_clock0_source_sel       <= `TGP_SRC_SYS;
      master_frame_format_sel     <= 1'b0;
      master_frame_pulse_polarity <= 1'b0;
      master_clock_polarity       <= 1'b0;
    end else begin
      out_clock3_source_sel <= output_clock_control_word[`TGP_OCK3_LO+1:`TGP_OCK3_LO];
      out_clock2_source_sel <= output_clock_control_word[`TGP_OCK2_LO+1:`TGP_OCK2_LO];
      out_clock1_source_sel <= output_clock_control_word[`TGP_OCK1_LO+1:`TGP_OCK1_LO];
      out_clock0_source_sel <= output_clock_control_word[`TGP_OCK0_LO+1:`TGP_OCK0_LO];
      master_frame_format_sel     <= input_clock_control_word[`TGP_ICK_FMT];
      master_frame_pulse_polarity <= input_clock_control_word[`TGP_ICK_FPPOL];
      master_clock_polarity       <= input_clock_control_word[`TGP_ICK_CKPOL];
    end
  end

  // ==========================================================
  // strap capture: synchronised, never loaded under reset
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_meta  <= 2'h0;
      strap_sync  <= 2'h0;
      master_freq <= 2'h0;
    end else begin
      strap_meta  <= master_freq_strap;
      strap_sync  <= strap_meta;
      master_freq <= strap_sync;
    end
  end

  // ==========================================================
  // aux clock frequency detection: count rising edges per 125 us window.
  // limitation: 100 MHz sampling cannot resolve edges above 50 MHz, so the
  // fastest code is taken from a high but aliased count; skew per rule 12
  // is not checked here
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_ck_meta <= 2'h0;
      aux_ck_sync <= 2'h0;
      aux_ck_prev <= 2'h0;
      aux_fp_meta <= 2'h0;
      aux_fp_sync <= 2'h0;
      frame_cnt   <= {`TGP_CNT_W{1'b0}};
    end else begin
      aux_ck_meta <= aux_clock_in;
      aux_ck_sync <= aux_ck_meta;
      aux_ck_prev <= aux_ck_sync;
      aux_fp_meta <= aux_frame_pulse_in;
      aux_fp_sync <= aux_fp_meta;
      frame_cnt   <= frame_end ? {`TGP_CNT_W{1'b0}} : frame_cnt + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : aux
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          edge_cnt[k] <= {`TGP_EDGE_W{1'b0}};
          aux_rate[k] <= `TGP_RATE_8M;
          aux_freq[2*k+1:2*k] <= `TGP_RATE_8M;
        end else begin
          if (frame_end) begin
            edge_cnt[k] <= {`TGP_EDGE_W{1'b0}};
            // each pair classified on its own count
            if (edge_cnt[k] >= `TGP_EDG_65M) begin
              aux_rate[k] <= `TGP_RATE_65M;
            end else if (edge_cnt[k] >= `TGP_EDG_32M) begin
              aux_rate[k] <= `TGP_RATE_32M;
            end else if (edge_cnt[k] >= `TGP_EDG_16M) begin
              aux_rate[k] <= `TGP_RATE_16M;
            end else begin
              aux_rate[k] <= `TGP_RATE_8M;
            end
          end else if (aux_ck_sync[k] & ~aux_ck_prev[k] & ~(&edge_cnt[k])) begin
            edge_cnt[k] <= edge_cnt[k] + 1'b1;
          end
          aux_freq[2*k+1:2*k] <= aux_rate[k];
        end
      end
    end
  endgenerate

endmodule

// ---- tgp_map.vh ----
// Purpose: constants for the tdm group provisioning block
// Assumes: included by tgp_prov.v, its checker and its bench
// Notes:   apb offsets are byte addresses, one 32-bit word per register
`ifndef TGP_MAP_VH
`define TGP_MAP_VH
// ==========================================================
// register offsets
`define TGP_ADDR_W        12
`define TGP_OFS_GROUP     12'h000
`define TGP_OFS_IN_CLK    12'h200
`define TGP_OFS_OUT_CLK   12'h204
`define TGP_OFS_STATUS    12'h208
`define TGP_OFS_AUX_RATE  12'h20C
`define TGP_GRP_LIMIT     12'h080
// ==========================================================
// group control word fields
`define TGP_IN_SRC_HI     1
`define TGP_IN_SRC_LO     0
`define TGP_IN_RATE_HI    3
`define TGP_IN_RATE_LO    2
`define TGP_OUT_SRC_HI    17
`define TGP_OUT_SRC_LO    16
`define TGP_OUT_RATE_HI   19
`define TGP_OUT_RATE_LO   18
`define TGP_GROUP_MASK    32'h000F000F
`define TGP_GROUP_RESET   32'h00000000
// ==========================================================
// output clock control word fields
`define TGP_OCK_MASK      32'h0060C183
`define TGP_OCK_RESET     32'h00000000
`define TGP_OCK3_LO       21
`define TGP_OCK2_LO       14
`define TGP_OCK1_LO       7
`define TGP_OCK0_LO       0
// ==========================================================
// input clock control word fields
`define TGP_ICK_FMT       2
`define TGP_ICK_FPPOL     1
`define TGP_ICK_CKPOL     0
`define TGP_ICK_MASK      32'h00000007
`define TGP_ICK_RESET     3'h0
// ==========================================================
// rate codes: 00 8M, 01 16M, 10 32M, 11 65M
`define TGP_RATE_8M       2'h0
`define TGP_RATE_16M      2'h1
`define TGP_RATE_32M      2'h2
`define TGP_RATE_65M      2'h3
`define TGP_SRC_SYS       2'h0
// ==========================================================
// aux clock detection, counts of sys_clk per frame (125 us)
`define TGP_FRAME_NS      125000
`define TGP_CLK_NS        10
`define TGP_FRAME_CYC     (`TGP_FRAME_NS / `TGP_CLK_NS)
`define TGP_CNT_W         16
`define TGP_EDGE_W        14
// edge counts per frame: 1024 8M, 2048 16M, 4096 32M, 8192 65M
`define TGP_EDG_16M       14'h0600
`define TGP_EDG_32M       14'h0C00
`define TGP_EDG_65M       14'h1800
`endif

// ---- tgp_prov_asserts.sv ----
// Purpose: port-level checks for tgp_prov
// Assumes: one-cycle pready answer; derived outputs settle two edges after a write
// Notes:   lane checks watch in group 0 and out group 31 only, to keep the cost low
`timescale 1ns/1ps
`include "tgp_map.vh"
// ==========================================================
// checker
module tgp_prov_asserts (
  input logic         sys_clk,
  input logic         rst_b,
  input logic         psel,
  input logic         penable,
  input logic         pwrite,
  input logic [11:0]  paddr,
  input logic [31:0]  pwdata,
  input logic         pready,
  input logic [1:0]   master_freq_strap,
  input logic [127:0] in_lane_active,
  input logic [127:0] out_lane_active,
  input logic [63:0]  in_group_rate,
  input logic [63:0]  out_group_rate,
  input logic [31:0]  in_group_half_cap,
  input logic [1:0]   out_clock3_source_sel,
  input logic [1:0]   out_clock0_source_sel,
  input logic [1:0]   master_freq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // lane mask for a rate code: top rate lane a, next a and b, else all four
  function automatic logic [3:0] lanes(input logic [1:0] r);
    return (r == 2'h3) ? 4'h1 : (r == 2'h2) ? 4'h3 : 4'hF;
  endfunction
  a_answer_next: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_in_lanes: assert property (
    $stable(in_group_rate[1:0]) |-> in_lane_active[3:0] == lanes(in_group_rate[1:0]))
    else $error("in lanes wrong");
  a_out_lanes: assert property (
    $stable(out_group_rate[63:62]) |->
      out_lane_active[127:124] == lanes(out_group_rate[63:62]))
    else $error("out lanes wrong");
  a_half_cap: assert property (
    $stable(in_group_rate[1:0]) |-> in_group_half_cap[0] == (in_group_rate[1:0] == 2'h0))
    else $error("capacity flag wrong");
  a_strap_sync: assert property (
    $stable(master_freq_strap)[*5] |-> master_freq == master_freq_strap)
    else $error("strap not followed");
  a_clk_write: assert property (
    psel && penable && pwrite && !pready && paddr == `TGP_OFS_OUT_CLK |-> ##2
      out_clock3_source_sel == $past(pwdata[22:21], 2) &&
      out_clock0_source_sel == $past(pwdata[1:0], 2))
    else $error("clock source not written");
  a_rate_write: assert property (
    psel && penable && pwrite && !pready && paddr == `TGP_OFS_GROUP |-> ##2
      in_group_rate[1:0] == $past(pwdata[3:2], 2) &&
      out_group_rate[1:0] == $past(pwdata[19:18], 2))
    else $error("group rate not written");
endmodule
bind tgp_prov tgp_prov_asserts i_tgp_prov_asserts (.sys_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .master_freq_strap, .in_lane_active,
  .out_lane_active, .in_group_rate, .out_group_rate, .in_group_half_cap,
  .out_clock3_source_sel, .out_clock0_source_sel, .master_freq);

// ---- tgp_aux_src.sv ----
// Purpose: far-side timing source, two aux clock and frame pulse pairs
// Assumes: 125 ns clock period, the slowest legal rate
// Notes:   free running; frame pulse low one clock in every 1000
`timescale 1ns/1ps
// ==========================================================
// aux timing source
module tgp_aux_src (
  output logic [1:0] aux_clock_in,
  output logic [1:0] aux_frame_pulse_in
);
  int n = 0;
  // both pairs share one edge, so skew stays far inside the limit
  // a 2 ns start offset keeps every aux edge clear of the sampling clock's edges
  initial begin
    aux_clock_in = 2'h0;
    aux_frame_pulse_in = 2'h3;
    #2;
    forever begin
      #62.5 aux_clock_in = ~aux_clock_in;
      if (aux_clock_in[0]) begin
        n = (n == 999) ? 0 : n + 1;
        aux_frame_pulse_in = (n == 0) ? 2'h0 : 2'h3;
      end
    end
  end
endmodule

// ---- tgp_prov_tb.sv ----
// Purpose: self-checking bench for tgp_prov over apb
// Assumes: aux pairs at 125 ns; detection window fixed at 12500 cycles
// Notes:   one idle cycle follows every apb transfer
`timescale 1ns/1ps
`include "tgp_map.vh"
module tgp_prov_tb;
  logic         sys_clk = 1'b0, rst_b = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd, in_half, out_half;
  logic [1:0]   strap = 2'h0, aux_ck, aux_fp, oc3, oc2, oc1, oc0, mfreq;
  logic [127:0] in_act, out_act;
  logic [63:0]  in_src, out_src, in_rate, out_rate;
  logic         m_fmt, m_fpp, m_ckp;
  logic [3:0]   aux_freq;
  int           mismatches = 0, n_tests = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  tgp_aux_src i_tgp_aux_src (.aux_clock_in(aux_ck), .aux_frame_pulse_in(aux_fp));
  tgp_prov i_tgp_prov (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .master_freq_strap(strap), .aux_clock_in(aux_ck),
    .aux_frame_pulse_in(aux_fp), .in_lane_active(in_act), .out_lane_active(out_act),
    .in_group_clk_source_sel(in_src), .out_group_clk_source_sel(out_src),
    .in_group_rate(in_rate), .out_group_rate(out_rate), .in_group_half_cap(in_half),
    .out_group_half_cap(out_half), .out_clock3_source_sel(oc3),
    .out_clock2_source_sel(oc2), .out_clock1_source_sel(oc1),
    .out_clock0_source_sel(oc0), .master_frame_format_sel(m_fmt),
    .master_frame_pulse_polarity(m_fpp), .master_clock_polarity(m_ckp),
    .master_freq(mfreq), .aux_freq(aux_freq));
  // ==========================================================
  // shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard: the run needs about 13400 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end
  function automatic logic [3:0] lanes(input logic [1:0] r);
    return (r == 2'h3) ? 4'h1 : (r == 2'h2) ? 4'h3 : 4'hF;
  endfunction
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no cycle count assumed: only the hang guard ends a wait that never answers
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(err, 1'b0, "write refused");
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk({err, rd}, {ee, e}, "read back");
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(in_act, {128{1'b1}}, "reset lanes");
    chk(out_half, 32'hFFFFFFFF, "reset capacity");
    chk({m_fmt, m_fpp, m_ckp}, 3'h0, "reset timing");
    rdx(`TGP_OFS_IN_CLK, 32'h0, 1'b0);
  endtask
  // external sources only on slowest-rate groups, as software must
  task automatic t_groups();
    logic [1:0]   ri, ro, si, so;
    logic [127:0] ea;
    for (int g = 0; g < 32; g++) begin
      ri = g[1:0];
      ro = ~g[1:0];
      si = (ri == 2'h0) ? g[3:2] : 2'h0;
      so = (ro == 2'h0) ? g[4:3] : 2'h0;
      ea[4*g+:4] = lanes(ri);
      wr(12'(4 * g), 32'hFFF0FFF0 | {12'h0, ro, so, 12'h0, ri, si});
      rdx(12'(4 * g), {12'h0, ro, so, 12'h0, ri, si}, 1'b0);
      chk({in_rate[2*g+:2], out_rate[2*g+:2]}, {ri, ro}, "rates");
      chk({in_src[2*g+:2], out_src[2*g+:2]}, {si, so}, "sources");
      chk(in_act[4*g+:4], lanes(ri), "in lanes");
      chk(out_act[4*g+:4], lanes(ro), "out lanes");
      chk({in_half[g], out_half[g]}, {ri == 2'h0, ro == 2'h0}, "capacity");
    end
    chk(in_act, ea, "all groups");
  endtask
  task automatic t_clocks();
    logic [2:0] v;
    wr(`TGP_OFS_OUT_CLK, 32'hFFBFBFFC);
    rdx(`TGP_OFS_OUT_CLK, 32'h00208180, 1'b0);
    chk({oc3, oc2, oc1, oc0}, 8'h6C, "clock sources");
    for (int i = 0; i < 2; i++) begin
      v = i ? 3'h2 : 3'h5;
      wr(`TGP_OFS_IN_CLK, {29'h1FFFFFFF, v});
      rdx(`TGP_OFS_IN_CLK, {29'h0, v}, 1'b0);
      chk({m_fmt, m_fpp, m_ckp}, v, "timing pol");
    end
  endtask
  task automatic t_strap();
    for (int s = 0; s < 4; s++) begin
      strap <= s[1:0];
      repeat (5) @(posedge sys_clk);
      chk(mfreq, s[1:0], "strap");
      rdx(`TGP_OFS_STATUS, {30'h0, s[1:0]}, 1'b0);
    end
    apb(1'b1, `TGP_OFS_STATUS, 32'h0);
    chk(err, 1'b1, "read-only write");
    rdx(12'h300, 32'h0, 1'b1);
  endtask
  task automatic t_aux();
    rdx(`TGP_OFS_AUX_RATE, 32'h0, 1'b0);
    repeat (13000) @(posedge sys_clk);
    chk(aux_freq, 4'h0, "aux rate");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_groups();
    t_clocks();
    t_strap();
    t_aux();
    report_and_stop();
  end
endmodule
